// *** src/sbe_exec.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Call pushes: pointer up, return address, pointer up, status word.
// - After pushing, program counter becomes itself plus sign-extended displacement.
// - Return address and branch base are the following instruction's address.
// - Accept 18-bit or 22-bit signed displacement, sign-extended to counter width.
// - Call leaves condition flags alone; status word only copied to stack.
// - Short call takes 5 cycles, 2 words; long call 6 cycles, 3 words.
// - Mask-ones branch completes in 5 cycles when not taken or 7 when taken, always 2 words.
// - Mask branch uses larger count when taken, smaller when not.
// - Taken mask branch target uses 7-bit counter-relative offset.
// - Mask is 16-bit immediate with upper or lower byte zero.
module sbe_exec
(
  // Clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        rst_i,
  // Program fetch
  input  wire logic                        word_valid_i,
  input  wire logic [sbe_pkg::WORD_W-1:0]  word_i,
  output logic                             word_take_o,
  output logic      [sbe_pkg::PC_W-1:0]    program_counter_o,
  // Core state inputs and operand select
  input  wire logic [sbe_pkg::WORD_W-1:0]  status_word_i,
  input  wire logic [sbe_pkg::WORD_W-1:0]  operand_i,
  output logic      [1:0]                  operand_sel_o,
  // Data-memory write port and stack
  output sbe_pkg::sbe_dwr_t                dmem_o,
  output logic      [sbe_pkg::PC_W-1:0]    stack_pointer_o,
  // Sequencing status
  output logic                             busy_o,
  output logic                             done_o
);

  sbe_pkg::sbe_st_t st_r;
  sbe_pkg::sbe_st_t st_nxt;
  logic [15:0]      mask16;

  // Sign extension of a displacement field to counter width
  function automatic logic [sbe_pkg::PC_W-1:0] sext22(input logic [sbe_pkg::LONG_W-1:0] v);
    sext22 = {{(sbe_pkg::PC_W-sbe_pkg::LONG_W){v[sbe_pkg::LONG_W-1]}}, v};
  endfunction

  // Mask immediate from the extension word
  // zero byte mask
  always_comb
  begin
    if (word_i[sbe_pkg::MASK_UPPER_B])
      mask16 = {word_i[15:sbe_pkg::MASK_BYTE_LSB], 8'h00};
    else
      mask16 = {8'h00, word_i[15:sbe_pkg::MASK_BYTE_LSB]};
  end

  // Next-state logic; every word taken advances the counter so it always names the next word
  always_comb
  begin
    logic [sbe_pkg::LONG_W-1:0] disp;
    logic                       hit;
    disp   = '0;
    hit    = 1'b0;
    st_nxt = st_r;
    st_nxt.take    = 1'b0;
    st_nxt.done    = 1'b0;
    st_nxt.dwr.we  = 1'b0;
    if (st_r.busy)
      st_nxt.cnt = st_r.cnt + 3'h1;
    unique case (st_r.state)
      sbe_pkg::S_IDLE:
      begin
        st_nxt.cnt = '0;
        if (word_valid_i && !st_r.take)
        begin
          st_nxt.take    = 1'b1;
          st_nxt.busy    = 1'b1;
          st_nxt.cnt     = 3'h1;
          st_nxt.pc      = st_r.pc + 24'h1;
          st_nxt.is_long = 1'b0;
          st_nxt.hi_bits = word_i[1:0];
          st_nxt.sel     = word_i[1:0];
          if ((word_i & sbe_pkg::PFX_MASK) == sbe_pkg::PFX_VAL)
          begin
            st_nxt.pfx     = {word_i[10:8], word_i[6], word_i[3:0]};
            st_nxt.is_long = 1'b1;
            st_nxt.total   = sbe_pkg::CYC_CALL_LONG;
            st_nxt.state   = sbe_pkg::S_OPC;
          end
          else if ((word_i & sbe_pkg::CALL_OPC_MASK) == sbe_pkg::CALL_OPC)
          begin
            st_nxt.is_mask = 1'b0;
            st_nxt.total   = sbe_pkg::CYC_CALL_SHORT;
            st_nxt.state   = sbe_pkg::S_EXT;
          end
          else if ((word_i & sbe_pkg::MASK_OPC_MASK) == sbe_pkg::MASK_OPC)
          begin
            st_nxt.is_mask = 1'b1;
            st_nxt.state   = sbe_pkg::S_EXT;
          end
          else
          begin
            // Not ours: word is left for the rest of the core
            st_nxt.take = 1'b0;
            st_nxt.busy = 1'b0;
            st_nxt.pc   = st_r.pc;
          end
        end
      end
      sbe_pkg::S_OPC:
      begin
        // Stalls here do not count toward the cycle budget; a word that shows up while take is
        // still high is already the next one, so refusing it would stretch every form by a cycle
        if (!word_valid_i)
          st_nxt.cnt = st_r.cnt;
        else if ((word_i & sbe_pkg::CALL_OPC_MASK) == sbe_pkg::CALL_OPC)
        begin
          st_nxt.take    = 1'b1;
          st_nxt.pc      = st_r.pc + 24'h1;
          st_nxt.is_mask = 1'b0;
          st_nxt.state   = sbe_pkg::S_EXT;
        end
        else
        begin
          // Unknown pairing: drop the prefix and go back to decode
          st_nxt.busy  = 1'b0;
          st_nxt.state = sbe_pkg::S_IDLE;
        end
      end
      sbe_pkg::S_EXT:
      begin
        if (!word_valid_i)
          st_nxt.cnt = st_r.cnt;
        else
        begin
          st_nxt.take = 1'b1;
          st_nxt.pc   = st_r.pc + 24'h1;
          if (st_r.is_mask)
          begin
            hit = ((operand_i & mask16) == mask16);
            st_nxt.total = hit ? sbe_pkg::CYC_MASK_TAKEN : sbe_pkg::CYC_MASK_SKIP;
            st_nxt.target = hit ? (st_r.pc + 24'h1 + {{(sbe_pkg::PC_W-sbe_pkg::REL_W){word_i[6]}}, word_i[6:0]})
                                : (st_r.pc + 24'h1);
            st_nxt.state  = sbe_pkg::S_WAIT;
          end
          else
          begin
            if (st_r.is_long)
              disp = {st_r.pfx[5:0], word_i};
            else
              disp = {{(sbe_pkg::LONG_W-sbe_pkg::SHORT_W){st_r.hi_bits[1]}}, st_r.hi_bits, word_i};
            st_nxt.target = st_r.pc + 24'h1 + sext22(disp);
            st_nxt.state  = sbe_pkg::S_PUSH_PC;
          end
        end
      end
      sbe_pkg::S_PUSH_PC:
      begin
        st_nxt.stack_pointer = st_r.stack_pointer + 24'h1;
        st_nxt.dwr.we        = 1'b1;
        st_nxt.dwr.addr      = st_r.stack_pointer + 24'h1;
        st_nxt.dwr.wdata     = st_r.pc;
        st_nxt.state         = sbe_pkg::S_PUSH_SR;
      end
      sbe_pkg::S_PUSH_SR:
      begin
        st_nxt.stack_pointer = st_r.stack_pointer + 24'h1;
        st_nxt.dwr.we        = 1'b1;
        st_nxt.dwr.addr      = st_r.stack_pointer + 24'h1;
        st_nxt.dwr.wdata     = {{(sbe_pkg::PC_W-sbe_pkg::WORD_W){1'b0}}, status_word_i};
        st_nxt.state         = sbe_pkg::S_JUMP;
      end
      sbe_pkg::S_JUMP, sbe_pkg::S_WAIT:
      begin
        if (st_r.cnt >= st_r.total - 3'h1)
        begin
          st_nxt.pc    = st_r.target;
          st_nxt.done  = 1'b1;
          st_nxt.busy  = 1'b0;
          st_nxt.state = sbe_pkg::S_IDLE;
        end
      end
      default:
        st_nxt.state = sbe_pkg::S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      st_r               <= '0;
      st_r.state         <= sbe_pkg::S_IDLE;
      st_r.pc            <= sbe_pkg::PC_RST;
      st_r.stack_pointer <= sbe_pkg::SP_RST;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs come straight from the state register
  assign word_take_o       = st_r.take;
  assign program_counter_o = st_r.pc;
  assign operand_sel_o     = st_r.sel;
  assign dmem_o            = st_r.dwr;
  assign stack_pointer_o   = st_r.stack_pointer;
  assign busy_o            = st_r.busy;
  assign done_o            = st_r.done;

  // Two pushes then write enable low, for a call without stalls
  a_push_order: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_r.state == sbe_pkg::S_PUSH_PC |=> dmem_o.we ##1 dmem_o.we ##1 !dmem_o.we)
    else $error("call push sequence broken");
  a_sp_step: assert property (@(posedge mclk_i) disable iff (rst_i)
    dmem_o.we |-> dmem_o.addr == stack_pointer_o && stack_pointer_o == $past(stack_pointer_o) + 24'h1)
    else $error("push address not new stack top");
  a_ret_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(dmem_o.we) |-> dmem_o.wdata == program_counter_o)
    else $error("return address is not next instruction");
  a_sr_push: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_r.state == sbe_pkg::S_PUSH_SR |=> dmem_o.wdata == {8'h00, $past(status_word_i)})
    else $error("status word not stacked");
  a_jump_target: assert property (@(posedge mclk_i) disable iff (rst_i)
    done_o |-> program_counter_o == $past(st_r.target))
    else $error("program counter not loaded with target");
  a_short_cycles: assert property (@(posedge mclk_i) disable iff (rst_i)
    done_o && !$past(st_r.is_mask) && !$past(st_r.is_long) |-> $past(st_r.cnt) == 3'h4)
    else $error("short call cycle count wrong");
  a_long_cycles: assert property (@(posedge mclk_i) disable iff (rst_i)
    done_o && !$past(st_r.is_mask) && $past(st_r.is_long) |-> $past(st_r.cnt) == 3'h5)
    else $error("long call cycle count wrong");
  a_mask_cycles: assert property (@(posedge mclk_i) disable iff (rst_i)
    done_o && $past(st_r.is_mask) |-> $past(st_r.cnt) >= 3'h4 && $past(st_r.cnt) <= 3'h7)
    else $error("mask branch outside 5 to 8 cycles");
  a_mask_outcome: assert property (@(posedge mclk_i) disable iff (rst_i)
    done_o && $past(st_r.is_mask) && $past(st_r.total) == 3'h5 |-> $past(st_r.target) == $past(st_r.pc))
    else $error("untaken mask branch moved the counter");

endmodule

// *** src/sbe_pkg.sv ***
package sbe_pkg;

  // Datapath widths
  localparam int PC_W    = 24;
  localparam int WORD_W  = 16;
  localparam int SHORT_W = 18;
  localparam int LONG_W  = 22;
  localparam int REL_W   = 7;
  localparam int CNT_W   = 3;

  // Opcode patterns, compared under their masks
  localparam logic [15:0] CALL_OPC      = 16'he26c;
  localparam logic [15:0] CALL_OPC_MASK = 16'hfffc;
  localparam logic [15:0] PFX_VAL       = 16'he030;
  localparam logic [15:0] PFX_MASK      = 16'hf8b0;
  localparam logic [15:0] MASK_OPC      = 16'h8e50;
  localparam logic [15:0] MASK_OPC_MASK = 16'hfffc;

  // Extension word fields of the mask test
  localparam int MASK_BYTE_LSB = 8;
  localparam int MASK_UPPER_B  = 7;

  // Cycle counts per form
  localparam logic [CNT_W-1:0] CYC_CALL_SHORT = 3'h5;
  localparam logic [CNT_W-1:0] CYC_CALL_LONG  = 3'h6;
  localparam logic [CNT_W-1:0] CYC_MASK_TAKEN = 3'h7;
  localparam logic [CNT_W-1:0] CYC_MASK_SKIP  = 3'h5;

  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 24'h000000;
  localparam logic [PC_W-1:0] SP_RST = 24'h000000;

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_OPC     = 3'b001,
    S_EXT     = 3'b010,
    S_PUSH_PC = 3'b011,
    S_PUSH_SR = 3'b100,
    S_JUMP    = 3'b101,
    S_WAIT    = 3'b110
  } sbe_state_t;

  // Data-memory write port
  typedef struct packed {
    logic            we;
    logic [PC_W-1:0] addr;
    logic [PC_W-1:0] wdata;
  } sbe_dwr_t;

  // Whole state of the sequencer
  typedef struct packed {
    sbe_state_t       state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] total;
    logic             is_mask;
    logic             is_long;
    logic [7:0]       pfx;
    logic [1:0]       hi_bits;
    logic [PC_W-1:0]  pc;
    logic [PC_W-1:0]  stack_pointer;
    logic [PC_W-1:0]  target;
    sbe_dwr_t         dwr;
    logic             take;
    logic             done;
    logic             busy;
    logic [1:0]       sel;
  } sbe_st_t;

endpackage

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // Block inputs, all given a value at time zero
  logic              mclk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              word_valid_i = 1'b0;
  logic [15:0]       word_i = 16'h0000;
  logic [15:0]       status_word_i = 16'h8a5c;
  logic [15:0]       operand_i = 16'h0000;
  // Block outputs
  logic              word_take_o;
  logic [23:0]       program_counter_o;
  logic [1:0]        operand_sel_o;
  sbe_pkg::sbe_dwr_t dmem_o;
  logic [23:0]       stack_pointer_o;
  logic              busy_o;
  logic              done_o;
  int                error_cnt = 0;
  int                total_checks = 0;

  sbe_exec dut_u
  (
    .mclk_i,
    .rst_i,
    .word_valid_i,
    .word_i,
    .word_take_o,
    .program_counter_o,
    .status_word_i,
    .operand_i,
    .operand_sel_o,
    .dmem_o,
    .stack_pointer_o,
    .busy_o,
    .done_o
  );

  // 200 MHz core clock
  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Flag compare; an unknown never matches
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s: got %b want %b", $time, msg, got, exp);
    end
  endtask

  // Address or data compare
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s: got %h want %h", $time, msg, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One word per cycle with no stall, so the cycle figures hold exactly
  task automatic run(input logic [15:0] w0, w1, w2, input int n, ncyc,
                     input logic [23:0] disp, input logic call, input logic [15:0] opnd);
    logic [15:0] w [3];
    logic [23:0] sp0;
    logic [23:0] nxt;
    int          nwr;
    w = '{w0, w1, w2};
    sp0 = stack_pointer_o;
    nxt = program_counter_o + 24'(n);
    nwr = 0;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge mclk_i);
      operand_i <= opnd;
      word_valid_i <= (i < n);
      word_i <= (i < n) ? w[i] : 16'h0000;
      #1;
      if (i >= 1 && i <= n)
        chk_bit(word_take_o, 1'b1, "word take");
      if (i == 1)
        chk_bit(busy_o, 1'b1, "busy");
      if (dmem_o.we === 1'b1)
      begin
        chk_val(24'(i - ncyc + 2), 24'(nwr), "push cycle");
        chk_val(dmem_o.addr, sp0 + 24'(nwr + 1), "push addr");
        chk_val(dmem_o.wdata, (nwr == 0) ? nxt : {8'h00, status_word_i}, "push data");
        nwr++;
      end
      if (done_o === 1'b1)
      begin
        chk_val(24'(i), 24'(ncyc), "cycles");
        chk_val(program_counter_o, nxt + disp, "target");
        chk_val(stack_pointer_o, sp0 + (call ? 24'h000002 : 24'h000000), "stack ptr");
        chk_val(24'(nwr), call ? 24'h000002 : 24'h000000, "pushes");
        chk_bit(busy_o, 1'b0, "busy after done");
        if (!call)
          chk_val(24'(operand_sel_o), 24'(w0[1:0]), "operand select");
        return;
      end
    end
    chk_bit(done_o, 1'b1, "completion");
  endtask

  // Counter, stack pointer, write enable and the three flags cleared by reset
  task automatic t_reset();
    chk_val(program_counter_o, sbe_pkg::PC_RST, "pc reset");
    chk_val(stack_pointer_o, sbe_pkg::SP_RST, "sp reset");
    chk_bit(dmem_o.we, 1'b0, "we reset");
    chk_bit(busy_o | done_o | word_take_o, 1'b0, "flags reset");
  endtask

  // Short calls, forward and backward
  task automatic t_short_call();
    run(16'he26d, 16'h2345, 16'h0000, 2, 5, 24'h012345, 1'b1, 16'h0000);
    run(16'he26f, 16'hfff0, 16'h0000, 2, 5, 24'hfffff0, 1'b1, 16'h0000);
  endtask

  // Long calls; the second sets an ignored prefix bit that must not leak in
  task automatic t_long_call();
    run(16'he17f, 16'he26c, 16'hff00, 3, 6, 24'hffff00, 1'b1, 16'h0000);
    run(16'he431, 16'he26c, 16'h0000, 3, 6, 24'h010000, 1'b1, 16'h0000);
  endtask

  // Mask branch: every operand select, both byte lanes, taken and not
  task automatic t_mask();
    run(16'h8e52, 16'h81fe, 16'h0000, 2, 7, 24'hfffffe, 1'b0, 16'hc1ff);
    run(16'h8e51, 16'h0f05, 16'h0000, 2, 5, 24'h000000, 1'b0, 16'hff0e);
    run(16'h8e53, 16'h3c10, 16'h0000, 2, 7, 24'h000010, 1'b0, 16'h003c);
    run(16'h8e50, 16'h3c90, 16'h0000, 2, 5, 24'h000000, 1'b0, 16'h003c);
  endtask

  // Stray word ignored, prefix then a non-call word abandoned, then a clean call
  task automatic t_refuse();
    logic [15:0] seq [5];
    logic [23:0] pc0;
    seq = '{16'h1234, 16'he030, 16'h5a5a, 16'h0000, 16'h0000};
    pc0 = program_counter_o;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge mclk_i);
      word_valid_i <= (i < 3);
      word_i <= seq[i];
      #1;
      chk_bit(word_take_o, (i == 2), "refused word");
      chk_bit(done_o, 1'b0, "no completion");
    end
    chk_val(program_counter_o, pc0 + 24'h000001, "pc after abort");
    chk_bit(busy_o, 1'b0, "idle after abort");
    run(16'he26c, 16'h0004, 16'h0000, 2, 5, 24'h000004, 1'b1, 16'h0000);
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_short_call();
    t_long_call();
    t_mask();
    t_refuse();
    stop_test();
  end

  // Watchdog, several times the expected run of about 77 cycles
  initial
  begin
    #5000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
endmodule
